// >>> inc/fp_logic_pkg.sv
// Shared constants and types for the significand logic and flag check unit
package fp_logic_pkg;
   // Operand formats
   localparam int SIG_W  = 64;
   localparam int EXP_W  = 17;
   localparam int FLAG_W = 6;
   localparam int NUM_SF = 4;
   localparam int IP_W   = 64;
   localparam int IMM_W  = 21;
   // Branch displacement: immediate scaled to 16-byte bundles
   localparam int BR_SHIFT = 4;
   localparam int BR_EXT_W = 25;
   // Implemented address widths, plain defaults
   localparam int VIRT_IMPL_BITS = 51;
   localparam int PHYS_IMPL_BITS = 44;
   // Fixed result fields
   localparam logic [EXP_W-1:0] INT_EXP    = 17'h1003e;
   localparam logic [EXP_W-1:0] NATVAL_EXP = 17'h1fffe;
   localparam logic [SIG_W-1:0] NATVAL_SIG = 64'h0;
   localparam logic             SIGN_POS   = 1'h0;
   // APB map, byte addresses
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_CTRL      = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_TRAP_DIS  = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_FLAGS     = 12'h008;
   localparam logic [ADDR_W-1:0] ADDR_INT_STAT  = 12'h00c;
   localparam logic [ADDR_W-1:0] ADDR_INT_MASK  = 12'h010;
   localparam logic [ADDR_W-1:0] ADDR_TARGET_LO = 12'h014;
   localparam logic [ADDR_W-1:0] ADDR_TARGET_HI = 12'h018;
   // Control bits
   localparam int CTRL_W      = 2;
   localparam int CTRL_TB_BIT = 0;
   localparam int CTRL_IT_BIT = 1;
   // Interrupt event bits
   localparam int INT_W      = 4;
   localparam int EV_BRANCH  = 0;
   localparam int EV_UNIMPL  = 1;
   localparam int EV_TBTRAP  = 2;
   localparam int EV_NAT     = 3;
   // Reset values
   localparam logic [CTRL_W-1:0]        RST_CTRL     = 2'h0;
   localparam logic [FLAG_W-1:0]        RST_TRAP_DIS = 6'h3f;
   localparam logic [NUM_SF*FLAG_W-1:0] RST_FLAGS    = 24'h0;
   localparam logic [INT_W-1:0]         RST_INT      = 4'h0;
   // Operation select
   typedef enum logic [1:0] {OP_AND, OP_ANDCM, OP_CHKF} op_t;
endpackage

// >>> hw/fp_sig_logic.sv
// Combinational significand AND / AND-complement with NaTVal propagation
`timescale 1ns/100ps
`default_nettype none
module fp_sig_logic (
   input  wire logic                            complement, // Invert second operand
   input  wire logic [fp_logic_pkg::SIG_W-1:0]  a_sig,      // First significand
   input  wire logic                            a_nat,      // First is NaTVal
   input  wire logic [fp_logic_pkg::SIG_W-1:0]  b_sig,      // Second significand
   input  wire logic                            b_nat,      // Second is NaTVal
   output logic      [fp_logic_pkg::SIG_W-1:0]  r_sig,      // Result significand
   output logic      [fp_logic_pkg::EXP_W-1:0]  r_exp,      // Result exponent
   output logic                                 r_sign,     // Result sign
   output logic                                 r_nat       // Result is NaTVal
);
   logic [fp_logic_pkg::SIG_W-1:0] b_eff;

   // Second operand, optionally complemented
   assign b_eff = complement ? ~b_sig : b_sig;

   // NaTVal wins over the computed value
   always_comb
   begin
      r_nat = a_nat | b_nat;
      if (r_nat)
      begin
         r_sig  = fp_logic_pkg::NATVAL_SIG;
         r_exp  = fp_logic_pkg::NATVAL_EXP;
         r_sign = fp_logic_pkg::SIGN_POS;
      end
      else
      begin
         r_sig  = a_sig & b_eff;
         r_exp  = fp_logic_pkg::INT_EXP;
         r_sign = fp_logic_pkg::SIGN_POS;
      end
   end
endmodule
`default_nettype wire

// >>> hw/fp_logic_flag_check.sv
// Significand logic and status flag check unit with APB control registers
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - AND writes bit-wise AND of significands
// - Logic results get integer exponent, positive sign
// - AND-complement inverts second significand first
// - Any NaTVal source yields NaTVal result
// - Branch on trap-enabled or unrecorded flags
// - Target is IP plus sign-extended bundle offset
// - Trap unimplemented target; trap if branch-trapping
module fp_logic_flag_check (
   input  wire logic                            pclk,                  // Core clock
   input  wire logic                            presetn,               // Async reset, low
   input  wire logic                            psel,                  // APB select
   input  wire logic                            penable,               // APB enable
   input  wire logic                            pwrite,                // APB write
   input  wire logic [fp_logic_pkg::ADDR_W-1:0] paddr,                 // APB address
   input  wire logic [31:0]                     pwdata,                // APB write data
   output logic      [31:0]                     prdata,                // APB read data
   output logic                                 pready,                // APB ready
   output logic                                 pslverr,               // APB error
   input  wire logic                            op_valid,              // Issue strobe
   input  wire fp_logic_pkg::op_t               op_sel,                // Operation
   input  wire logic                            qualifying_predicate,  // Predicate value
   input  wire logic [fp_logic_pkg::SIG_W-1:0]  src1_sig,              // Source 1 significand
   input  wire logic                            src1_nat,              // Source 1 NaTVal
   input  wire logic [fp_logic_pkg::SIG_W-1:0]  src2_sig,              // Source 2 significand
   input  wire logic                            src2_nat,              // Source 2 NaTVal
   input  wire logic [fp_logic_pkg::IP_W-1:0]   ip,                    // Bundle address
   input  wire logic [fp_logic_pkg::IMM_W-1:0]  imm21,                 // Branch immediate
   input  wire logic [1:0]                      status_field_select,   // Status field 0..3
   output logic                                 res_valid,             // Register write pulse
   output logic      [fp_logic_pkg::SIG_W-1:0]  res_sig,               // Result significand
   output logic      [fp_logic_pkg::EXP_W-1:0]  res_exp,               // Result exponent
   output logic                                 res_sign,              // Result sign
   output logic                                 res_nat,               // Result NaTVal
   output logic                                 branch_taken,          // Branch pulse
   output logic      [fp_logic_pkg::IP_W-1:0]   branch_target,         // New IP
   output logic                                 unimpl_addr_trap,      // Trap pulse
   output logic                                 taken_branch_trap,     // Trap pulse
   output logic                                 irq                    // Interrupt level
);
   typedef struct packed {
      logic [fp_logic_pkg::CTRL_W-1:0]                     ctrl;
      logic [fp_logic_pkg::FLAG_W-1:0]                     trap_dis;
      logic [fp_logic_pkg::NUM_SF*fp_logic_pkg::FLAG_W-1:0] flags;
      logic [fp_logic_pkg::INT_W-1:0]                      int_stat;
      logic [fp_logic_pkg::INT_W-1:0]                      int_mask;
      logic [31:0]                                         rdata;
      logic                                                res_valid;
      logic [fp_logic_pkg::SIG_W-1:0]                      res_sig;
      logic [fp_logic_pkg::EXP_W-1:0]                      res_exp;
      logic                                                res_sign;
      logic                                                res_nat;
      logic                                                br_taken;
      logic [fp_logic_pkg::IP_W-1:0]                       br_target;
      logic                                                ua_trap;
      logic                                                tb_trap;
   } state_t;

   state_t q;
   state_t next_q;

   logic [fp_logic_pkg::SIG_W-1:0]    lg_sig;
   logic [fp_logic_pkg::EXP_W-1:0]    lg_exp;
   logic                              lg_sign;
   logic                              lg_nat;
   logic [fp_logic_pkg::FLAG_W-1:0]   sel_flags;
   logic                              chk_hit;
   logic [fp_logic_pkg::BR_EXT_W-1:0] disp_raw;
   logic [fp_logic_pkg::IP_W-1:0]     target;
   logic                              unimpl_virt;
   logic                              unimpl_phys;
   logic                              addr_hit;
   logic                              apb_access;
   logic                              fire;

   // Shared logic datapath
   fp_sig_logic u_logic (
      .complement (op_sel == fp_logic_pkg::OP_ANDCM),
      .a_sig      (src1_sig),
      .a_nat      (src1_nat),
      .b_sig      (src2_sig),
      .b_nat      (src2_nat),
      .r_sig      (lg_sig),
      .r_exp      (lg_exp),
      .r_sign     (lg_sign),
      .r_nat      (lg_nat)
   );

   // Operation only counts with predicate set
   assign fire = op_valid & qualifying_predicate;

   // Flag check against traps and main field
   assign sel_flags = q.flags[status_field_select*fp_logic_pkg::FLAG_W +: fp_logic_pkg::FLAG_W];
   assign chk_hit   = (|(sel_flags & ~q.trap_dis))
                    | (|(sel_flags & ~q.flags[fp_logic_pkg::FLAG_W-1:0]));

   // Displacement counted in bundles, sign-extended to IP width
   assign disp_raw = {imm21, {fp_logic_pkg::BR_SHIFT{1'b0}}};
   assign target   = ip + {{(fp_logic_pkg::IP_W-fp_logic_pkg::BR_EXT_W){disp_raw[fp_logic_pkg::BR_EXT_W-1]}},
                           disp_raw};

   // Virtual needs sign-extended top, physical needs zero top
   assign unimpl_virt = !((&target[fp_logic_pkg::IP_W-1:fp_logic_pkg::VIRT_IMPL_BITS-1])
                        | ~(|target[fp_logic_pkg::IP_W-1:fp_logic_pkg::VIRT_IMPL_BITS-1]));
   assign unimpl_phys = |target[fp_logic_pkg::IP_W-1:fp_logic_pkg::PHYS_IMPL_BITS];

   // Address decode; zero wait states
   always_comb
   begin
      unique case (paddr)
         fp_logic_pkg::ADDR_CTRL,
         fp_logic_pkg::ADDR_TRAP_DIS,
         fp_logic_pkg::ADDR_FLAGS,
         fp_logic_pkg::ADDR_INT_STAT,
         fp_logic_pkg::ADDR_INT_MASK,
         fp_logic_pkg::ADDR_TARGET_LO,
         fp_logic_pkg::ADDR_TARGET_HI: addr_hit = 1'b1;
         default:                      addr_hit = 1'b0;
      endcase
   end

   assign apb_access = psel & penable;
   assign pready     = 1'b1;
   assign pslverr    = apb_access & ~addr_hit;

   // Next state: bus, datapath, then events so set beats clear
   always_comb
   begin
      next_q           = q;
      next_q.res_valid = 1'b0;
      next_q.br_taken  = 1'b0;
      next_q.ua_trap   = 1'b0;
      next_q.tb_trap   = 1'b0;
      // Read data captured in setup so it stands through access
      if (psel && !penable)
      begin
         unique case (paddr)
            fp_logic_pkg::ADDR_CTRL:      next_q.rdata = {30'h0, q.ctrl};
            fp_logic_pkg::ADDR_TRAP_DIS:  next_q.rdata = {26'h0, q.trap_dis};
            fp_logic_pkg::ADDR_FLAGS:     next_q.rdata = {8'h0, q.flags};
            fp_logic_pkg::ADDR_INT_STAT:  next_q.rdata = {28'h0, q.int_stat};
            fp_logic_pkg::ADDR_INT_MASK:  next_q.rdata = {28'h0, q.int_mask};
            fp_logic_pkg::ADDR_TARGET_LO: next_q.rdata = q.br_target[31:0];
            fp_logic_pkg::ADDR_TARGET_HI: next_q.rdata = q.br_target[63:32];
            default:                      next_q.rdata = 32'h0;
         endcase
      end
      // Writes land on the access edge
      if (apb_access && pwrite)
      begin
         unique case (paddr)
            fp_logic_pkg::ADDR_CTRL:     next_q.ctrl = pwdata[fp_logic_pkg::CTRL_W-1:0];
            fp_logic_pkg::ADDR_TRAP_DIS: next_q.trap_dis = pwdata[fp_logic_pkg::FLAG_W-1:0];
            fp_logic_pkg::ADDR_FLAGS:    next_q.flags = pwdata[fp_logic_pkg::NUM_SF*fp_logic_pkg::FLAG_W-1:0];
            fp_logic_pkg::ADDR_INT_STAT: next_q.int_stat = q.int_stat & ~pwdata[fp_logic_pkg::INT_W-1:0];
            fp_logic_pkg::ADDR_INT_MASK: next_q.int_mask = pwdata[fp_logic_pkg::INT_W-1:0];
            default:                     next_q.int_mask = q.int_mask;
         endcase
      end
      // Datapath; nothing moves without the predicate
      if (fire)
      begin
         unique case (op_sel)
            fp_logic_pkg::OP_AND,
            fp_logic_pkg::OP_ANDCM:
            begin
               next_q.res_valid = 1'b1;
               next_q.res_sig   = lg_sig;
               next_q.res_exp   = lg_exp;
               next_q.res_sign  = lg_sign;
               next_q.res_nat   = lg_nat;
               if (lg_nat)
               begin
                  next_q.int_stat[fp_logic_pkg::EV_NAT] = 1'b1;
               end
            end
            fp_logic_pkg::OP_CHKF:
            begin
               if (chk_hit)
               begin
                  next_q.br_taken  = 1'b1;
                  next_q.br_target = target;
                  next_q.ua_trap   = q.ctrl[fp_logic_pkg::CTRL_IT_BIT] ? unimpl_virt : unimpl_phys;
                  next_q.tb_trap   = q.ctrl[fp_logic_pkg::CTRL_TB_BIT];
                  next_q.int_stat[fp_logic_pkg::EV_BRANCH] = 1'b1;
                  next_q.int_stat[fp_logic_pkg::EV_UNIMPL] = next_q.int_stat[fp_logic_pkg::EV_UNIMPL]
                                                           | next_q.ua_trap;
                  next_q.int_stat[fp_logic_pkg::EV_TBTRAP] = next_q.int_stat[fp_logic_pkg::EV_TBTRAP]
                                                           | next_q.tb_trap;
               end
            end
            default:
            begin
               next_q.res_valid = 1'b0;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q           <= '0;
         q.ctrl      <= fp_logic_pkg::RST_CTRL;
         q.trap_dis  <= fp_logic_pkg::RST_TRAP_DIS;
         q.flags     <= fp_logic_pkg::RST_FLAGS;
         q.int_stat  <= fp_logic_pkg::RST_INT;
         q.int_mask  <= fp_logic_pkg::RST_INT;
      end
      else
      begin
         q <= next_q;
      end
   end

   // Outputs straight from state
   assign prdata            = q.rdata;
   assign res_valid         = q.res_valid;
   assign res_sig           = q.res_sig;
   assign res_exp           = q.res_exp;
   assign res_sign          = q.res_sign;
   assign res_nat           = q.res_nat;
   assign branch_taken      = q.br_taken;
   assign branch_target     = q.br_target;
   assign unimpl_addr_trap  = q.ua_trap;
   assign taken_branch_trap = q.tb_trap;
   assign irq               = |(q.int_stat & q.int_mask);

   // Checks, all on pclk
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_and_value: assert property (
      (fire && op_sel == fp_logic_pkg::OP_AND && !src1_nat && !src2_nat)
      |=> res_valid && res_sig == ($past(src1_sig) & $past(src2_sig)))
      else $error("and result wrong");

   chk_int_exponent: assert property (
      (fire && (op_sel == fp_logic_pkg::OP_AND || op_sel == fp_logic_pkg::OP_ANDCM) && !src1_nat && !src2_nat)
      |=> res_exp == fp_logic_pkg::INT_EXP && res_sign == 1'b0 && !res_nat)
      else $error("logic exponent or sign wrong");

   chk_andcm_value: assert property (
      (fire && op_sel == fp_logic_pkg::OP_ANDCM && !src1_nat && !src2_nat)
      |=> res_sig == ($past(src1_sig) & ~$past(src2_sig)))
      else $error("and-complement result wrong");

   // Status bit lands with the result, so a clear one cycle later cannot hide it
   logic int_stat_nat_seen;
   assign int_stat_nat_seen = q.int_stat[fp_logic_pkg::EV_NAT];

   chk_nat_propagate: assert property (
      (fire && (op_sel == fp_logic_pkg::OP_AND || op_sel == fp_logic_pkg::OP_ANDCM) && (src1_nat || src2_nat))
      |=> res_valid && res_nat && res_exp == fp_logic_pkg::NATVAL_EXP && int_stat_nat_seen)
      else $error("natval not propagated");

   // Reference decision shifts the field down rather than using the indexed select
   logic [fp_logic_pkg::NUM_SF*fp_logic_pkg::FLAG_W-1:0] ref_shift;
   logic                                                 ref_hit;
   assign ref_shift = q.flags >> (status_field_select * fp_logic_pkg::FLAG_W);
   assign ref_hit   = (|(ref_shift[fp_logic_pkg::FLAG_W-1:0] & ~q.trap_dis))
                    | (|(ref_shift[fp_logic_pkg::FLAG_W-1:0] & ~q.flags[fp_logic_pkg::FLAG_W-1:0]));

   chk_branch_decision: assert property (
      (fire && op_sel == fp_logic_pkg::OP_CHKF) |=> branch_taken == $past(ref_hit))
      else $error("flag check decision wrong");

   chk_branch_target: assert property (
      branch_taken
      |-> branch_target == $past(ip) + {{39{$past(imm21[20])}}, $past(imm21), 4'h0})
      else $error("branch target wrong");

   chk_unimpl_trap: assert property (
      unimpl_addr_trap |-> branch_taken && (q.ctrl[fp_logic_pkg::CTRL_IT_BIT] ||
                                            branch_target[63:fp_logic_pkg::PHYS_IMPL_BITS] != 0))
      else $error("unimplemented address trap without cause");

   chk_tb_trap: assert property (
      branch_taken |-> taken_branch_trap == $past(q.ctrl[fp_logic_pkg::CTRL_TB_BIT]))
      else $error("taken branch trap wrong");

   chk_pred_gate: assert property (
      (op_valid && !qualifying_predicate && !(psel && penable && pwrite))
      |=> !res_valid && !branch_taken && $stable(branch_target) && $stable(res_sig))
      else $error("state changed with predicate clear");

   chk_irq_level: assert property (
      (q.int_stat & q.int_mask) != 0 |-> irq)
      else $error("irq not raised");

   // Side effects on status and result registers
   chk_branch_status: assert property (
      branch_taken |-> q.int_stat[fp_logic_pkg::EV_BRANCH])
      else $error("branch event not recorded");

   chk_trap_with_branch: assert property (
      (unimpl_addr_trap || taken_branch_trap) |-> branch_taken)
      else $error("trap pulse without taken branch");

   chk_target_hold: assert property (
      !branch_taken |-> $stable(branch_target))
      else $error("branch target moved without a branch");

   chk_check_quiet: assert property (
      (fire && op_sel == fp_logic_pkg::OP_CHKF) |=> !res_valid)
      else $error("flag check wrote a register result");

   chk_result_hold: assert property (
      !res_valid |-> $stable(res_sig) && $stable(res_exp) && $stable(res_nat))
      else $error("result changed without a write pulse");

   chk_nat_fields: assert property (
      res_valid && res_nat |-> res_sig == fp_logic_pkg::NATVAL_SIG && res_sign == fp_logic_pkg::SIGN_POS)
      else $error("natval result fields wrong");

   chk_refused_op: assert property (
      (op_valid && op_sel == fp_logic_pkg::op_t'(2'h3)) |=> !res_valid && !branch_taken)
      else $error("unused operation code had an effect");

   // Bus side: errors only in access, unmapped writes are dropped
   chk_slverr_phase: assert property (
      pslverr |-> psel && penable)
      else $error("error response outside access phase");

   chk_unmapped_write: assert property (
      (psel && penable && pwrite && pslverr)
      |=> $stable(q.ctrl) && $stable(q.trap_dis) && $stable(q.flags) && $stable(q.int_mask))
      else $error("unmapped write changed a register");

   chk_mask_write: assert property (
      (psel && penable && pwrite && paddr == fp_logic_pkg::ADDR_INT_MASK)
      |=> q.int_mask == $past(pwdata[fp_logic_pkg::INT_W-1:0]))
      else $error("mask write did not land");

   cov_and_op: cover property (fire && op_sel == fp_logic_pkg::OP_AND ##1 res_valid);
   cov_andcm_nat: cover property (fire && op_sel == fp_logic_pkg::OP_ANDCM && src2_nat ##1 res_nat);
   cov_branch_trap: cover property (branch_taken && taken_branch_trap ##1 irq);
   cov_unimpl_trap: cover property (unimpl_addr_trap);
endmodule
`default_nettype wire

// >>> verif/issue_model.sv
// Issue pipeline model: presents one operation to the unit per call
`timescale 1ns/100ps
`default_nettype none
module issue_model (
   input  wire logic                           pclk,     // Core clock
   output logic                                op_valid, // Issue strobe
   output var fp_logic_pkg::op_t               op_sel,   // Operation
   output logic                                pred,     // Predicate
   output logic     [fp_logic_pkg::SIG_W-1:0]  s1,       // Source 1
   output logic                                n1,       // Source 1 NaTVal
   output logic     [fp_logic_pkg::SIG_W-1:0]  s2,       // Source 2
   output logic                                n2,       // Source 2 NaTVal
   output logic     [fp_logic_pkg::IP_W-1:0]   ip,       // Bundle address
   output logic     [fp_logic_pkg::IMM_W-1:0]  imm,      // Immediate
   output logic     [1:0]                      sfs       // Status field
);
   // Idle from time zero
   initial
   begin
      op_valid = 1'b0;
      op_sel = fp_logic_pkg::OP_AND;
      {pred, s1, n1, s2, n2, ip, imm, sfs} = '0;
   end
   // Held for one edge, then operands scrambled so stale values cannot pass
   task automatic issue(input fp_logic_pkg::op_t o, input logic p, input logic [63:0] a, input logic an,
                        input logic [63:0] b, input logic bn, input logic [63:0] ipv, input logic [20:0] immv,
                        input logic [1:0] sfv);
      @(posedge pclk);
      op_valid <= 1'b1;
      op_sel <= o;
      pred <= p;
      {s1, n1, s2, n2, ip, imm, sfs} <= {a, an, b, bn, ipv, immv, sfv};
      @(posedge pclk);
      op_valid <= 1'b0;
      {s1, s2, ip, imm} <= ~{a, b, ipv, immv};
   endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the significand logic and flag check unit
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0]              paddr;
   logic [31:0]              pwdata, prdata, rd;
   logic                     op_valid, pred, n1, n2, rv, rnat, rsign, bt, ut, tt, err;
   fp_logic_pkg::op_t        op_sel;
   logic [63:0]              s1, s2, ip, rsig, btgt, a, b, ipv;
   logic [20:0]              imm, immv;
   logic [16:0]              rexp;
   logic [1:0]               sfs, sfv, ctl;
   logic                     an, bn;
   logic [23:0]              fl;
   logic [5:0]               dis;
   logic [66:0]              e;
   logic [82:0]              el;
   int                       n_errors, checks_done;

   fp_logic_flag_check u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_valid(op_valid),
      .op_sel(op_sel), .qualifying_predicate(pred), .src1_sig(s1), .src1_nat(n1), .src2_sig(s2), .src2_nat(n2),
      .ip(ip), .imm21(imm), .status_field_select(sfs), .res_valid(rv), .res_sig(rsig), .res_exp(rexp),
      .res_sign(rsign), .res_nat(rnat), .branch_taken(bt), .branch_target(btgt), .unimpl_addr_trap(ut),
      .taken_branch_trap(tt), .irq(irq));
   issue_model u_pm (.pclk(pclk), .op_valid(op_valid), .op_sel(op_sel), .pred(pred), .s1(s1), .n1(n1),
      .s2(s2), .n2(n2), .ip(ip), .imm(imm), .sfs(sfs));

   // 4 ns core clock
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic conclude();
      $display("checks=%0d errors=%0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check(input logic [127:0] seen, input logic [127:0] expd);
      checks_done++;
      if (seen !== expd)
      begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expd);
      end
   endtask

   // APB master; two idle edges first so earlier results have landed in status
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
      int n;
      n = 0;
      repeat (2) @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         n_errors++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [11:0] ad, input logic [31:0] x, input logic xe);
      apb(1'b0, ad, 32'h0);
      check({err, rd}, {xe, x});
   endtask

   task automatic op(input fp_logic_pkg::op_t o, input logic p);
      u_pm.issue(o, p, a, an, b, bn, ipv, immv, sfv);
      #1;
   endtask

   // Expected logic result: nat, sign, exponent, significand
   function automatic logic [82:0] exp_logic(input logic cm);
      if (an | bn)
         return {1'b1, 1'b0, fp_logic_pkg::NATVAL_EXP, fp_logic_pkg::NATVAL_SIG};
      return {1'b0, fp_logic_pkg::SIGN_POS, fp_logic_pkg::INT_EXP, a & (cm ? ~b : b)};
   endfunction

   // Expected flag check: hit, unimplemented trap, branch trap, target
   function automatic logic [66:0] exp_br();
      logic [5:0]  f;
      logic [63:0] t;
      logic        hit;
      f = fl[sfv*6 +: 6];
      hit = |(f & ~dis) | |(f & ~fl[5:0]);
      t = ipv + {{39{immv[20]}}, immv, 4'h0};
      return {hit, hit & (ctl[1] ? !(&t[63:50] | ~|t[63:50]) : |t[63:44]), hit & ctl[0], t};
   endfunction

   // Main sequence
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, n_errors, checks_done} = '0;
      {a, b, an, bn, ipv, immv, sfv} = '0;
      presetn = 1'b0;
      void'($urandom(6206));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(fp_logic_pkg::ADDR_CTRL, 32'h0, 1'b0);
      rdchk(fp_logic_pkg::ADDR_TRAP_DIS, 32'h3f, 1'b0);
      rdchk(fp_logic_pkg::ADDR_FLAGS, 32'h0, 1'b0);
      rdchk(12'h01c, 32'h0, 1'b1);
      apb(1'b1, fp_logic_pkg::ADDR_INT_MASK, 32'hf);
      // Random logic ops, NaTVal sources and zero predicates among them
      for (int i = 0; i < 24; i++)
      begin
         a = (i == 0) ? '1 : {$urandom, $urandom};
         b = (i == 0) ? '1 : {$urandom, $urandom};
         an = (i % 5 == 1);
         bn = (i % 7 == 3);
         el = exp_logic(i[0]);
         op(i[0] ? fp_logic_pkg::OP_ANDCM : fp_logic_pkg::OP_AND, 1'b1);
         check({rv, rnat, rsign, rexp, rsig}, {1'b1, el});
         a = ~a;
         op(i[1] ? fp_logic_pkg::OP_AND : fp_logic_pkg::op_t'(2'h3), i[1] ? 1'b0 : 1'b1);
         check({rv, rnat, rsign, rexp, rsig}, {1'b0, el});
      end
      // NaTVal events raise the interrupt, cleared by writing ones
      rdchk(fp_logic_pkg::ADDR_INT_STAT, 32'h8, 1'b0);
      check(irq, 1'b1);
      apb(1'b1, fp_logic_pkg::ADDR_INT_STAT, 32'hf);
      #1;
      check(irq, 1'b0);
      // Random flag checks over all four status fields and both translation modes
      for (int i = 0; i < 24; i++)
      begin
         fl = (i == 0) ? 24'h0 : 24'($urandom);
         dis = 6'($urandom);
         ctl = 2'($urandom);
         ipv = i[2] ? {$urandom, $urandom} : {32'h0, $urandom & 32'hffff_fff0};
         immv = 21'($urandom);
         sfv = i[1:0];
         apb(1'b1, fp_logic_pkg::ADDR_FLAGS, {8'h0, fl});
         apb(1'b1, fp_logic_pkg::ADDR_TRAP_DIS, {26'h0, dis});
         apb(1'b1, fp_logic_pkg::ADDR_CTRL, {30'h0, ctl});
         apb(1'b1, fp_logic_pkg::ADDR_INT_MASK, {28'h0, i[3], 3'h7});
         e = exp_br();
         op(fp_logic_pkg::OP_CHKF, 1'b1);
         check({bt, ut, tt, bt ? btgt : 64'h0}, {e[66:64], e[66] ? e[63:0] : 64'h0});
         if (e[66])
         begin
            rdchk(fp_logic_pkg::ADDR_INT_STAT, {28'h0, 1'b0, e[64], e[65], 1'b1}, 1'b0);
            check(irq, 1'b1);
            rdchk(fp_logic_pkg::ADDR_TARGET_LO, e[31:0], 1'b0);
            rdchk(fp_logic_pkg::ADDR_TARGET_HI, e[63:32], 1'b0);
            apb(1'b1, fp_logic_pkg::ADDR_INT_STAT, 32'hf);
            ipv = ~ipv;
            op(fp_logic_pkg::OP_CHKF, 1'b0);
            check({bt, btgt}, {1'b0, e[63:0]});
         end
      end
      conclude();
   end
endmodule
`default_nettype wire
